/* design/srm_pkg.sv */
/*
 * srm_pkg: offsets, field positions and fixed values of the storage
 * controller register window.
 * assumes: a 16-bit byte address into the window, 32-bit data words.
 */
package srm_pkg;

	// ****************************************************************
	// widths and fixed words
	// ****************************************************************
	localparam int          ADDR_W       = 16;
	localparam int          WORD_W       = 32;
	localparam logic [31:0] WORD_ZERO    = 32'h0000_0000;
	localparam logic [3:0]  BE_ALL       = 4'hF;

	// ****************************************************************
	// register byte offsets
	// ****************************************************************
	localparam logic [15:0] OFS_FEAT_LO  = 16'h0000;
	localparam logic [15:0] OFS_FEAT_HI  = 16'h0004;
	localparam logic [15:0] OFS_REV      = 16'h0008;
	localparam logic [15:0] OFS_MSET     = 16'h000C;
	localparam logic [15:0] OFS_MCLR     = 16'h0010;
	localparam logic [15:0] OFS_CFG      = 16'h0014;
	localparam logic [15:0] OFS_RSV_A    = 16'h0018;
	localparam logic [15:0] OFS_STATE    = 16'h001C;
	localparam logic [15:0] OFS_SUBRST   = 16'h0020;
	localparam logic [15:0] OFS_AQS      = 16'h0024;
	localparam logic [15:0] OFS_ASQ      = 16'h0028;
	localparam logic [15:0] OFS_ACQ      = 16'h0030;
	localparam logic [15:0] OFS_BUFP     = 16'h0038;
	localparam logic [15:0] OFS_BUFX     = 16'h003C;
	localparam logic [15:0] OFS_BINFO    = 16'h0040;
	localparam logic [15:0] OFS_BSEL     = 16'h0044;
	localparam logic [15:0] OFS_BHOST    = 16'h0048;
	localparam logic [15:0] OFS_BELL     = 16'h1000;
	localparam logic [15:0] OFS_HI_WORD  = 16'h0004;

	// ****************************************************************
	// feature summary field positions
	// ****************************************************************
	localparam int          FS_STRD_LSB  = 32;
	localparam int          FS_MID_LSB   = 36;
	localparam int          FS_MIN_LSB   = 48;
	localparam int          FS_MAX_LSB   = 52;
	localparam int          BELL_MIN_EXP = 2;

endpackage

/* design/srm_acc_if.sv */
/*
 * srm_acc_if: one host access as seen by the window's sub-blocks.
 * assumes: driven by the top from its host port, one access a cycle.
 */
`timescale 1ns/100ps
interface srm_acc_if;
	logic        valid;
	logic        write;
	logic [15:0] addr;
	logic [31:0] wdata;
	logic [3:0]  be;

	modport src (output valid, output write, output addr, output wdata, output be);
	modport snk (input valid, input write, input addr, input wdata, input be);
endinterface

/* design/srm_rw_word.sv */
/*
 * srm_rw_word: one 64-bit read/write register reached as two words.
 * assumes: BASE is 8-byte aligned; the top registers the read data.
 */
`timescale 1ns/100ps
module srm_rw_word #(
	parameter logic [15:0] BASE = 16'h0000,
	parameter bit          EN   = 1'b1
) (
	input  wire logic        clk,
	input  wire logic        arst_n,
	srm_acc_if.snk           acc,
	output      logic        hit,
	output      logic [31:0] rdata,
	output      logic [63:0] value
);
	typedef struct packed {
		logic [63:0] val;
	} srm_word_st_t;

	srm_word_st_t st_reg;
	srm_word_st_t st_next;

	if (BASE[2:0] != 3'h0) begin : g_chk
		$error("srm_rw_word: BASE not 8-byte aligned");
	end

	// decode of either word; absent register never hits
	assign hit   = EN && acc.valid && (acc.addr[15:3] == BASE[15:3]);
	assign rdata = acc.addr[2] ? st_reg.val[63:32] : st_reg.val[31:0];
	assign value = st_reg.val;

	// byte-lane merge into the addressed half
	always_comb begin
		int idx;
		idx     = 0;
		st_next = st_reg;
		if (hit && acc.write) begin
			for (int i = 0; i < 4; i++) begin
				idx = (acc.addr[2] ? 4 : 0) + i;
				if (acc.be[i]) begin
					st_next.val[idx*8 +: 8] = acc.wdata[i*8 +: 8];
				end
			end
		end
	end

	// state register
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end
endmodule

/* design/srm_bell_decode.sv */
/*
 * srm_bell_decode: strided queue doorbell decode and vendor region hit.
 * assumes: NUM_Q queue pairs, admin pair included, fit in the window.
 */
`timescale 1ns/100ps
module srm_bell_decode #(
	parameter int       NUM_Q = 4,
	parameter logic [3:0] DOORBELL_SPACING_EXP = 4'h0
) (
	input  wire logic             clk,
	input  wire logic             arst_n,
	srm_acc_if.snk                acc,
	output      logic             vendor,
	output      logic             ring,
	output      logic             ring_cq,
	output      logic [$clog2((NUM_Q > 1) ? NUM_Q : 2)-1:0] ring_q,
	output      logic [31:0]      ring_val
);
	localparam int          QW         = (NUM_Q > 1) ? $clog2(NUM_Q) : 1;
	localparam int          STRIDE     = 4 << DOORBELL_SPACING_EXP;
	localparam int          SLOTS      = 2 * NUM_Q;
	localparam logic [16:0] VEND_START = 17'(srm_pkg::OFS_BELL) + 17'(SLOTS * STRIDE);

	typedef struct packed {
		logic          ring;
		logic          cq;
		logic [QW-1:0] q;
		logic [31:0]   val;
	} srm_bell_st_t;

	srm_bell_st_t st_reg;
	srm_bell_st_t st_next;
	logic [15:0]  rel;
	logic [15:0]  slot;
	logic         in_bells;
	logic         aligned;

	if (NUM_Q < 1 || VEND_START > 17'h10000) begin : g_chk
		$error("srm_bell_decode: doorbells do not fit the window");
	end

	// slot index from the spacing exponent; gaps between slots decode as nothing
	assign rel      = acc.addr - srm_pkg::OFS_BELL;
	assign slot     = rel >> (srm_pkg::BELL_MIN_EXP + DOORBELL_SPACING_EXP);
	assign in_bells = (acc.addr >= srm_pkg::OFS_BELL) && (17'(acc.addr) < VEND_START);
	assign aligned  = (rel & 16'(STRIDE - 1)) == 16'h0000;
	assign vendor   = acc.valid && (17'(acc.addr) >= VEND_START);

	// full-word write to a slot rings it: even slot tail, odd slot head
	always_comb begin
		st_next      = st_reg;
		st_next.ring = acc.valid && acc.write && in_bells && aligned && (acc.be == srm_pkg::BE_ALL);
		if (st_next.ring) begin
			st_next.q   = slot[QW:1];
			st_next.cq  = slot[0];
			st_next.val = acc.wdata;
		end
	end

	// state register
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign ring     = st_reg.ring;
	assign ring_cq  = st_reg.cq;
	assign ring_q   = st_reg.q;
	assign ring_val = st_reg.val;
endmodule

/* design/srm_regmap.sv */
/*
 * srm_regmap: register window of a host-attached storage controller.
 * assumes: host accesses arrive on the clk domain one per cycle as a
 * valid strobe with address, data and byte enables; the command engine
 * behind the doorbells and status source run on the same clock.
 */
`timescale 1ns/100ps

module srm_regmap #(
	parameter int          NUM_Q      = 4,
	parameter logic [3:0]  DOORBELL_SPACING_EXP      = 4'h0,
	parameter logic [3:0]  MPS_MIN    = 4'h0,
	parameter logic [3:0]  MPS_MAX    = 4'h0,
	parameter logic [9:0]  CAP_MID    = 10'h000,
	parameter logic [31:0] CAP_LOW    = 32'h0000_0000,
	parameter logic [31:0] REVISION   = 32'h0001_0000,
	parameter logic [31:0] SUBRST_KEY = 32'h0000_0001, // arbitrary trigger value
	parameter bit          HAS_SUBRST = 1'b1,
	parameter bit          HAS_BUF    = 1'b1,
	parameter bit          HAS_BOOT   = 1'b1
) (
	input  wire logic          clk,
	input  wire logic          arst_n,
	input  wire logic          host_valid,
	input  wire logic          host_write,
	input  wire logic [15:0]   host_addr,
	input  wire logic [31:0]   host_wdata,
	input  wire logic [3:0]    host_be,
	output      logic          host_ack,
	output      logic [31:0]   host_rdata,
	input  wire logic [31:0]   status_in,
	input  wire logic [31:0]   buf_place_in,
	input  wire logic [31:0]   buf_extent_in,
	input  wire logic [31:0]   boot_info_in,
	output      logic [31:0]   config_out,
	output      logic [31:0]   irq_mask_out,
	output      logic [31:0]   admin_sizes_out,
	output      logic [63:0]   asq_base_out,
	output      logic [63:0]   acq_base_out,
	output      logic [31:0]   boot_sel_out,
	output      logic [63:0]   boot_buf_out,
	output      logic          subsys_reset_pulse,
	output      logic          bell_pulse,
	output      logic          bell_is_cq,
	output      logic [$clog2((NUM_Q > 1) ? NUM_Q : 2)-1:0] bell_queue,
	output      logic [31:0]   bell_value,
	output      logic          vendor_pulse
);
	// ****************************************************************
	// derived constants and checks
	// ****************************************************************
	localparam int          QW       = (NUM_Q > 1) ? $clog2(NUM_Q) : 1;
	localparam int          STRIDE   = 4 << DOORBELL_SPACING_EXP;
	localparam logic [16:0] VEND_BEG = 17'(srm_pkg::OFS_BELL) + 17'(2 * NUM_Q * STRIDE);
	localparam bit          HAS_VEND = VEND_BEG < 17'h10000;
	localparam logic [15:0] VEND_ADR = VEND_BEG[15:0];

	// feature summary assembled from fixed fields; 63:56 and 47:46 stay zero
	function automatic logic [63:0] feat_word();
		logic [63:0] f;
		f                                  = '0;
		f[31:0]                            = CAP_LOW;
		f[srm_pkg::FS_STRD_LSB +: 4]       = DOORBELL_SPACING_EXP;
		f[srm_pkg::FS_MID_LSB +: 10]       = CAP_MID;
		f[srm_pkg::FS_MIN_LSB +: 4]        = MPS_MIN;
		f[srm_pkg::FS_MAX_LSB +: 4]        = MPS_MAX;
		return f;
	endfunction

	localparam logic [63:0] FEAT = feat_word();

	if (MPS_MIN > MPS_MAX) begin : g_chk_page
		$error("srm_regmap: smallest page exponent above largest");
	end
	if (NUM_Q < 1) begin : g_chk_q
		$error("srm_regmap: at least the admin queue pair is needed");
	end

	// ****************************************************************
	// state
	// ****************************************************************
	typedef struct packed {
		logic        ack;
		logic [31:0] rdata;
		logic [31:0] mask;
		logic [31:0] cfg;
		logic [31:0] aqs;
		logic [31:0] bsel;
		logic [31:0] subrst;
		logic        subrst_pulse;
		logic        vend_pulse;
	} srm_top_st_t;

	srm_top_st_t st_reg;
	srm_top_st_t st_next;

	logic [15:0] word_addr;
	logic [31:0] be_bits;
	logic [31:0] rd_word;
	logic [31:0] merged;
	logic        asq_hit;
	logic        acq_hit;
	logic        bhost_hit;
	logic [31:0] asq_rd;
	logic [31:0] acq_rd;
	logic [31:0] bhost_rd;
	logic        vend_hit;

	// ****************************************************************
	// access carrier to the sub-blocks
	// ****************************************************************
	srm_acc_if acc_bus ();

	// one word per access; bytes of a neighbour are never touched
	assign acc_bus.valid = host_valid;
	assign acc_bus.write = host_write;
	assign acc_bus.addr  = host_addr;
	assign acc_bus.wdata = host_wdata;
	assign acc_bus.be    = host_be;
	assign word_addr     = {host_addr[15:2], 2'b00};

	// byte enables spread to a bit mask
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			be_bits[i*8 +: 8] = {8{host_be[i]}};
		end
	end

	// ****************************************************************
	// 64-bit ring base and boot buffer registers and doorbells
	// ****************************************************************
	srm_rw_word #(.BASE(srm_pkg::OFS_ASQ), .EN(1'b1)) u_asq (
		.clk    (clk),
		.arst_n (arst_n),
		.acc    (acc_bus),
		.hit    (asq_hit),
		.rdata  (asq_rd),
		.value  (asq_base_out)
	);

	srm_rw_word #(.BASE(srm_pkg::OFS_ACQ), .EN(1'b1)) u_acq (
		.clk    (clk),
		.arst_n (arst_n),
		.acc    (acc_bus),
		.hit    (acq_hit),
		.rdata  (acq_rd),
		.value  (acq_base_out)
	);

	srm_rw_word #(.BASE(srm_pkg::OFS_BHOST), .EN(HAS_BOOT)) u_bhost (
		.clk    (clk),
		.arst_n (arst_n),
		.acc    (acc_bus),
		.hit    (bhost_hit),
		.rdata  (bhost_rd),
		.value  (boot_buf_out)
	);

	srm_bell_decode #(.NUM_Q(NUM_Q), .DOORBELL_SPACING_EXP(DOORBELL_SPACING_EXP)) u_bell (
		.clk      (clk),
		.arst_n   (arst_n),
		.acc      (acc_bus),
		.vendor   (vend_hit),
		.ring     (bell_pulse),
		.ring_cq  (bell_is_cq),
		.ring_q   (bell_queue),
		.ring_val (bell_value)
	);

	// ****************************************************************
	// read and write decode
	// ****************************************************************
	// reads: anything not named below, doorbells included, reads zero
	always_comb begin
		rd_word = srm_pkg::WORD_ZERO;
		case (word_addr)
			srm_pkg::OFS_FEAT_LO: rd_word = FEAT[31:0];
			srm_pkg::OFS_FEAT_HI: rd_word = FEAT[63:32];
			srm_pkg::OFS_REV:     rd_word = REVISION;
			srm_pkg::OFS_MSET:    rd_word = st_reg.mask;
			srm_pkg::OFS_MCLR:    rd_word = st_reg.mask;
			srm_pkg::OFS_CFG:     rd_word = st_reg.cfg;
			srm_pkg::OFS_STATE:   rd_word = status_in;
			srm_pkg::OFS_AQS:     rd_word = st_reg.aqs;
			srm_pkg::OFS_SUBRST: begin
				if (HAS_SUBRST) begin
					rd_word = st_reg.subrst;
				end
			end
			srm_pkg::OFS_BUFP: begin
				if (HAS_BUF) begin
					rd_word = buf_place_in;
				end
			end
			srm_pkg::OFS_BUFX: begin
				if (HAS_BUF) begin
					rd_word = buf_extent_in;
				end
			end
			srm_pkg::OFS_BINFO: begin
				if (HAS_BOOT) begin
					rd_word = boot_info_in;
				end
			end
			srm_pkg::OFS_BSEL: begin
				if (HAS_BOOT) begin
					rd_word = st_reg.bsel;
				end
			end
			default: begin
				if (asq_hit) begin
					rd_word = asq_rd;
				end else if (acq_hit) begin
					rd_word = acq_rd;
				end else if (bhost_hit) begin
					rd_word = bhost_rd;
				end
			end
		endcase
	end

	// written bytes masked by the byte enables
	always_comb begin
		merged = (host_wdata & be_bits);
	end

	// next state: ack every access, writes land on the same edge
	always_comb begin
		st_next              = st_reg;
		st_next.ack          = host_valid;
		st_next.subrst_pulse = 1'b0;
		st_next.vend_pulse   = vend_hit;
		if (host_valid && !host_write) begin
			st_next.rdata = rd_word;
		end
		if (host_valid && host_write) begin
			case (word_addr)
				srm_pkg::OFS_MSET: st_next.mask = st_reg.mask | merged;
				srm_pkg::OFS_MCLR: st_next.mask = st_reg.mask & ~merged;
				srm_pkg::OFS_CFG:  st_next.cfg  = (st_reg.cfg & ~be_bits) | merged;
				srm_pkg::OFS_AQS:  st_next.aqs  = (st_reg.aqs & ~be_bits) | merged;
				srm_pkg::OFS_SUBRST: begin
					if (HAS_SUBRST) begin
						st_next.subrst       = (st_reg.subrst & ~be_bits) | merged;
						st_next.subrst_pulse = (((st_reg.subrst & ~be_bits) | merged) == SUBRST_KEY);
					end
				end
				srm_pkg::OFS_BSEL: begin
					if (HAS_BOOT) begin
						st_next.bsel = (st_reg.bsel & ~be_bits) | merged;
					end
				end
				default: begin
					// read-only, reserved and absent locations drop the write
				end
			endcase
		end
	end

	// ****************************************************************
	// registers and outputs
	// ****************************************************************
	// state register
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	// outputs straight from state
	assign host_ack           = st_reg.ack;
	assign host_rdata         = st_reg.rdata;
	assign config_out         = st_reg.cfg;
	assign irq_mask_out       = st_reg.mask;
	assign admin_sizes_out    = st_reg.aqs;
	assign boot_sel_out       = st_reg.bsel;
	assign subsys_reset_pulse = st_reg.subrst_pulse;
	assign vendor_pulse       = st_reg.vend_pulse;

	// ****************************************************************
	// assertions
	// ****************************************************************
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!arst_n);

	sequence rd_at(logic [15:0] a);
		host_valid && !host_write && word_addr == a;
	endsequence

	sequence wr_full(logic [15:0] a);
		host_valid && host_write && word_addr == a && host_be == srm_pkg::BE_ALL;
	endsequence

	sequence pulse_once;
		subsys_reset_pulse ##1 !subsys_reset_pulse;
	endsequence

	feat_high_a: assert property (rd_at(srm_pkg::OFS_FEAT_HI) |=> host_ack && host_rdata == FEAT[63:32])
		else $error("feature summary high word wrong");

	feat_low_a: assert property (rd_at(srm_pkg::OFS_FEAT_LO) |=> host_rdata == FEAT[31:0])
		else $error("feature summary low word wrong");

	rsvd_read_a: assert property (rd_at(srm_pkg::OFS_RSV_A) |=> host_rdata == srm_pkg::WORD_ZERO)
		else $error("reserved word not zero");

	rsvd_write_a: assert property (wr_full(srm_pkg::OFS_RSV_A) |=> $stable(config_out) && $stable(irq_mask_out))
		else $error("reserved write changed state");

	absent_boot_a: assert property (rd_at(srm_pkg::OFS_BINFO) |=> host_rdata == (HAS_BOOT ? $past(boot_info_in) : srm_pkg::WORD_ZERO))
		else $error("boot info read wrong");

	subrst_fire_a: assert property ((wr_full(srm_pkg::OFS_SUBRST) and (HAS_SUBRST && host_wdata == SUBRST_KEY)) |=> pulse_once)
		else $error("subsystem reset pulse missing");

	sizes_store_a: assert property (wr_full(srm_pkg::OFS_AQS) |=> admin_sizes_out == $past(host_wdata))
		else $error("admin sizes not stored");

	acq_high_a: assert property (wr_full(srm_pkg::OFS_ACQ + srm_pkg::OFS_HI_WORD) ##1 !host_valid |-> ##1 acq_base_out[63:32] == $past(host_wdata, 2))
		else $error("completion ring base high word not stored");

	admin_bell_a: assert property (wr_full(srm_pkg::OFS_BELL) |=> bell_pulse && bell_queue == '0 && !bell_is_cq)
		else $error("admin tail doorbell not rung");

	head_bell_a: assert property (wr_full(srm_pkg::OFS_BELL + 16'(STRIDE)) |=> bell_pulse && bell_is_cq && bell_queue == '0)
		else $error("admin head doorbell not rung");

	bell_read_a: assert property (rd_at(srm_pkg::OFS_BELL) |=> host_rdata == srm_pkg::WORD_ZERO && !bell_pulse)
		else $error("doorbell read not zero");

	vendor_hit_a: assert property ((HAS_VEND && host_valid && host_addr == VEND_ADR) |=> vendor_pulse && !bell_pulse)
		else $error("vendor region start wrong");
endmodule

/* testbench/srm_host_model.sv */
/*
 * srm_host_model: host processor issuing single word accesses.
 * assumes: one access at a time, answered by host_ack a cycle later.
 */
`timescale 1ns/100ps
module srm_host_model (
	input  wire logic        clk,
	output      logic        host_valid,
	output      logic        host_write,
	output      logic [15:0] host_addr,
	output      logic [31:0] host_wdata,
	output      logic [3:0]  host_be,
	input  wire logic        host_ack,
	input  wire logic [31:0] host_rdata
);
	// idle bus at time zero
	initial begin
		host_valid = 1'b0;
		host_write = 1'b0;
		host_addr  = 16'h0000;
		host_wdata = 32'h0000_0000;
		host_be    = 4'h0;
	end

	// ordered, never locked, aligned word accesses only
	// reserved reads are checked by the bench, never relied on here
	task automatic access(input logic w, input logic [15:0] a, input logic [31:0] d,
		input logic [3:0] be, output logic [31:0] rd, output logic ack);
		@(posedge clk);
		#1;
		host_valid = 1'b1;
		host_write = w;
		host_addr  = {a[15:2], 2'b00};
		host_wdata = d;
		host_be    = be;
		@(posedge clk);
		#1;
		// released address, data and byte-enable lines show garbage, not the last value
		host_valid = 1'b0;
		host_addr  = ~host_addr;
		host_wdata = ~d;
		host_be    = ~be;
		rd = host_rdata;
		ack = host_ack;
	endtask
endmodule

/* testbench/srm_regmap_tb.sv */
/*
 * srm_regmap_tb: self-checking bench of the register window.
 * assumes: srm_host_model drives the host port; 25 MHz clock.
 */
`timescale 1ns/100ps
module srm_regmap_tb;
	localparam logic [3:0]  DOORBELL_SPACING_EXP = 4'h1;
	localparam logic [3:0]  PMIN  = 4'h1;
	localparam logic [3:0]  PMAX  = 4'h5;
	localparam logic [9:0]  MID   = 10'h2A5;
	localparam logic [31:0] LOW   = 32'h0F0A_1234;
	localparam logic [31:0] REV   = 32'h0001_0300;
	localparam logic [31:0] KEY   = 32'h0000_00A5;
	localparam logic [15:0] STEP  = 16'h0004 << DOORBELL_SPACING_EXP;
	localparam int          LIMIT = 2000;
	localparam logic [63:0] FEAT  = {8'h00, PMAX, PMIN, 2'b00, MID, DOORBELL_SPACING_EXP, LOW};
	localparam logic [15:0] RWO [9] = '{16'h0014, 16'h0024, 16'h0028, 16'h002C, 16'h0030,
		16'h0034, 16'h0044, 16'h0048, 16'h004C};
	localparam logic [15:0] ROO [10] = '{16'h0000, 16'h0008, 16'h0018, 16'h001C, 16'h0038,
		16'h003C, 16'h0040, 16'h0050, 16'h0F00, 16'h1000};

	logic        clk = 1'b0;
	logic        arst_n = 1'b0;
	logic        host_valid, host_write, host_ack, ackd;
	logic [15:0] host_addr;
	logic [31:0] host_wdata, host_rdata, rdat, d, m;
	logic [3:0]  host_be;
	logic [31:0] status_in = 32'h0000_0000;
	logic [31:0] place_in = 32'h0000_0000;
	logic [31:0] extent_in = 32'h0000_0000;
	logic [31:0] info_in = 32'h0000_0000;
	logic [31:0] config_out, irq_mask_out, admin_sizes_out, boot_sel_out, bell_value;
	logic [63:0] asq_base_out, acq_base_out, boot_buf_out;
	logic        subsys_reset_pulse, bell_pulse, bell_is_cq, vendor_pulse;
	logic [1:0]  bell_queue;
	logic [31:0] sh [9];
	logic [31:0] re [10];
	int          err_count = 0;
	int          n_tests = 0;
	int          cycles = 0;

	// clock, reset and hang guard
	always #20 clk = ~clk;
	always @(posedge clk) begin
		cycles++;
		if (cycles >= LIMIT) begin
			err_count++;
			tally_and_finish();
		end
	end

	srm_host_model srm_host_model_i (.clk(clk), .host_valid(host_valid), .host_write(host_write),
		.host_addr(host_addr), .host_wdata(host_wdata), .host_be(host_be), .host_ack(host_ack),
		.host_rdata(host_rdata));

	srm_regmap #(.NUM_Q(4), .DOORBELL_SPACING_EXP(DOORBELL_SPACING_EXP), .MPS_MIN(PMIN), .MPS_MAX(PMAX), .CAP_MID(MID),
		.CAP_LOW(LOW), .REVISION(REV), .SUBRST_KEY(KEY)) srm_regmap_i (.clk(clk),
		.arst_n(arst_n), .host_valid(host_valid), .host_write(host_write), .host_addr(host_addr),
		.host_wdata(host_wdata), .host_be(host_be), .host_ack(host_ack), .host_rdata(host_rdata),
		.status_in(status_in), .buf_place_in(place_in), .buf_extent_in(extent_in),
		.boot_info_in(info_in), .config_out(config_out), .irq_mask_out(irq_mask_out),
		.admin_sizes_out(admin_sizes_out), .asq_base_out(asq_base_out),
		.acq_base_out(acq_base_out), .boot_sel_out(boot_sel_out), .boot_buf_out(boot_buf_out),
		.subsys_reset_pulse(subsys_reset_pulse), .bell_pulse(bell_pulse),
		.bell_is_cq(bell_is_cq), .bell_queue(bell_queue), .bell_value(bell_value),
		.vendor_pulse(vendor_pulse));

	// compare and count
	task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
		n_tests++;
		if (seen !== exp) begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// one access, answered a cycle later
	task automatic acc(input logic w, input logic [15:0] a, input logic [31:0] dd, input logic [3:0] be);
		srm_host_model_i.access(w, a, dd, be, rdat, ackd);
		check("ack", ackd, 1'b1);
	endtask

	task automatic rd_chk(input string what, input logic [15:0] a, input logic [31:0] exp);
		acc(1'b0, a, 32'h0000_0000, 4'h0);
		check(what, rdat, exp);
	endtask

	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// main sequence
	initial begin
		void'($urandom(65322));
		status_in = $urandom;
		place_in = $urandom;
		extent_in = $urandom;
		info_in = $urandom;
		repeat (10) @(posedge clk);
		#1;
		arst_n = 1'b1;
		check("config reset", config_out, 32'h0000_0000);
		check("asq reset", asq_base_out, 64'h0);
		// feature summary fields and revision
		rd_chk("feat lo", 16'h0000, FEAT[31:0]);
		rd_chk("feat hi", 16'h0004, FEAT[63:32]);
		rd_chk("revision", 16'h0008, REV);
		// read/write registers with a partial byte write on config
		for (int i = 0; i < 9; i++) begin
			sh[i] = $urandom;
			acc(1'b1, RWO[i], sh[i], 4'hF);
		end
		d = $urandom;
		acc(1'b1, 16'h0014, d, 4'h5);
		sh[0] = {sh[0][31:24], d[23:16], sh[0][15:8], d[7:0]};
		for (int i = 0; i < 9; i++)
			rd_chk("rw readback", RWO[i], sh[i]);
		check("config out", config_out, sh[0]);
		check("sizes out", admin_sizes_out, sh[1]);
		check("asq out", asq_base_out, {sh[3], sh[2]});
		check("acq out", acq_base_out, {sh[5], sh[4]});
		check("bsel out", boot_sel_out, sh[6]);
		check("bbuf out", boot_buf_out, {sh[8], sh[7]});
		// read-only, reserved and doorbell places read back unchanged after writes
		re = '{FEAT[31:0], REV, 32'h0, status_in, place_in, extent_in, info_in, 32'h0, 32'h0, 32'h0};
		for (int i = 0; i < 10; i++) begin
			acc(1'b1, ROO[i], $urandom, 4'hF);
			rd_chk("ro place", ROO[i], re[i]);
		end
		// mask set then clear
		m = $urandom;
		d = $urandom;
		acc(1'b1, 16'h000C, m, 4'hF);
		acc(1'b1, 16'h0010, d, 4'hF);
		rd_chk("mask", 16'h000C, m & ~d);
		check("mask out", irq_mask_out, m & ~d);
		// every doorbell slot, tail and head
		for (int s = 0; s < 8; s++) begin
			d = $urandom;
			acc(1'b1, 16'h1000 + 16'(s) * STEP, d, 4'hF);
			check("bell pulse", bell_pulse, 1'b1);
			check("bell cq", bell_is_cq, s[0]);
			check("bell queue", bell_queue, s[2:1]);
			check("bell value", bell_value, d);
			check("no vendor", vendor_pulse, 1'b0);
		end
		acc(1'b1, 16'h1000 + STEP + 16'h0004, $urandom, 4'hF);
		check("gap bell", bell_pulse, 1'b0);
		acc(1'b1, 16'h1000, $urandom, 4'h7);
		check("part bell", bell_pulse, 1'b0);
		acc(1'b1, 16'h1000 + 16'h0008 * STEP, $urandom, 4'hF);
		check("vendor", vendor_pulse, 1'b1);
		check("vendor bell", bell_pulse, 1'b0);
		// subsystem reset trigger
		acc(1'b1, 16'h0020, KEY, 4'hF);
		check("subrst", subsys_reset_pulse, 1'b1);
		rd_chk("subrst rd", 16'h0020, KEY);
		acc(1'b1, 16'h0020, ~KEY, 4'hF);
		check("subrst off", subsys_reset_pulse, 1'b0);
		tally_and_finish();
	end
endmodule
